// file: design/apb_decode.sv
// APB address decode that turns a byte address into a register index and a hit flag.
`timescale 1ns/1ps
module apb_decode (
   input wire logic [13:0] i_paddr,
   output logic [11:0] o_index,
   output logic o_hit
);
   // Any byte address inside a word of the mapped set answers as a hit; bits 1:0 are ignored.
   always_comb begin
      o_index = i_paddr[13:2];
      case (i_paddr[13:2])
         pcstk_pkg::IDX_FLAGS_SHADOW, pcstk_pkg::IDX_WORKING_SHADOW,
         pcstk_pkg::IDX_BANK_SELECT_SHADOW, pcstk_pkg::IDX_UPPER_LATCH_SHADOW,
         pcstk_pkg::IDX_POINTER0_LOW_SHADOW, pcstk_pkg::IDX_POINTER0_HIGH_SHADOW,
         pcstk_pkg::IDX_POINTER1_LOW_SHADOW, pcstk_pkg::IDX_POINTER1_HIGH_SHADOW,
         pcstk_pkg::IDX_STACK_INDEX, pcstk_pkg::IDX_STACK_TOP_LOW,
         pcstk_pkg::IDX_STACK_TOP_HIGH, pcstk_pkg::IDX_PC_LOW_BYTE,
         pcstk_pkg::IDX_UPPER_ADDRESS_LATCH, pcstk_pkg::IDX_FAULT_STATUS,
         pcstk_pkg::IDX_IRQ_MASK, pcstk_pkg::IDX_CONTROL, pcstk_pkg::IDX_PC_VIEW: o_hit = 1'b1;
         default: o_hit = 1'b0;
      endcase
   end
endmodule

// file: design/program_counter_and_stack.sv
// Program counter sequencer with a sixteen-entry return stack and an APB register slave.
// Contract
// - Counter is 15 bits; low byte accessible.
// - Every reset clears the whole counter, except a fault reset in the same cycle as an APB low byte write.
// - Low byte write copies latch into upper bits.
// - Call: operand low bits, latch bits 6:3.
// - Computed call: working low, latch upper.
// - Work offset jump adds unsigned working value.
// - Relative jump adds signed operand.
// - Sixteen entries of 15 bits, separate.
// - Push on calls/interrupt, pop on returns.
// - Push and pop leave latch unchanged.
// - Fault reset off: stack wraps circularly.
// - Overflow and underflow flags always set.
// - Stack index is five bits wide.
// - Index then top registers reach any entry.
// - Push increments first; pop loads first.
// - Index resets to all ones, empty.
// - Fault reset on: reset and flag.
`timescale 1ns/1ps
module program_counter_and_stack #(
   parameter int DEPTH_BITS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Sequencer command from the instruction decoder and vectoring logic.
   input wire logic [3:0] i_op,
   input wire logic [10:0] i_call_operand,
   input wire logic [8:0] i_rel_operand,
   input wire logic [7:0] i_working,
   input wire logic [7:0] i_pc_low_wdata,
   input wire logic [14:0] i_vector,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [13:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Core-side results.
   output logic [14:0] o_pc,
   output logic o_fault_reset,
   output logic o_irq
);
   // Whole state, registered as one word.
   typedef struct packed {
      // Counter and latch.
      logic [14:0] pc;
      logic [6:0] upper_address_latch;

      // Stack control.
      logic [4:0] stack_index;
      logic stack_fault_reset_enable;

      // Faults and mask.
      logic [1:0] status;
      logic [1:0] mask;

      // Shadow copies.
      logic [7:0] flags_shadow;
      logic [7:0] working_shadow;
      logic [7:0] bank_select_shadow;
      logic [7:0] upper_latch_shadow;
      logic [7:0] pointer0_low_shadow;
      logic [7:0] pointer0_high_shadow;
      logic [7:0] pointer1_low_shadow;
      logic [7:0] pointer1_high_shadow;

      // Registered outputs.
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic fault_reset;
      logic irq;
   } state_t;

   state_t cur;
   state_t next_cur;

   logic [11:0] reg_index;
   logic reg_hit;
   pcstk_pkg::pc_op_t op;

   // Entry store and register decode.
   stack_port_if #(.DEPTH_BITS(DEPTH_BITS)) stk ();

   return_stack_mem #(.DEPTH_BITS(DEPTH_BITS)) u_mem (
      .i_clk_sys(i_clk_sys),
      .i_ce(i_ce),
      .port(stk.store)
   );

   apb_decode u_dec (
      .i_paddr(i_paddr),
      .o_index(reg_index),
      .o_hit(reg_hit)
   );

   // Slot that an index value selects; the low four bits give circular wrap.
   function automatic logic [DEPTH_BITS-1:0] slot_of(input logic [4:0] idx);
      slot_of = idx[DEPTH_BITS-1:0];
   endfunction

   // Counter after fetch plus a 15-bit offset, with carries across 256-word pages.
   function automatic logic [14:0] branch_target(input logic [14:0] pc, input logic [14:0] off);
      branch_target = 15'(pc + 15'h0001 + off);
   endfunction

   assign op = pcstk_pkg::pc_op_t'(i_op);

   // Sequencer, stack control and register file in one next-state process.
   always_comb begin
      logic push;
      logic pop;
      logic access;
      logic [4:0] idx_up;
      logic [14:0] top;

      next_cur = cur;
      push = 1'b0;
      pop = 1'b0;
      access = i_psel && i_penable;
      idx_up = 5'(cur.stack_index + 5'h01);
      top = stk.rdata;
      // The port idles on the current slot.
      stk.we = 1'b0;
      stk.waddr = slot_of(cur.stack_index);
      stk.wdata = cur.pc;
      stk.raddr = slot_of(cur.stack_index);
      // Bus answer and fault pulse stand one cycle.
      next_cur.pready = 1'b0;
      next_cur.pslverr = 1'b0;
      next_cur.fault_reset = 1'b0;

      // Counter loading for each command; the latch itself is never touched here.
      case (op)
         // Fetch advances by one.
         pcstk_pkg::OP_STEP: begin
            next_cur.pc = 15'(cur.pc + 15'h0001);
         end

         // A call takes its page bits from latch bits 6:3.
         pcstk_pkg::OP_CALL: begin
            push = 1'b1;
            next_cur.pc = {cur.upper_address_latch[6:3], i_call_operand};
         end

         // A computed call takes the whole latch.
         pcstk_pkg::OP_COMPUTED_CALL: begin
            push = 1'b1;
            next_cur.pc = {cur.upper_address_latch, i_working};
         end

         // Vectoring pushes like a call.
         pcstk_pkg::OP_INTERRUPT: begin
            push = 1'b1;
            next_cur.pc = i_vector;
         end

         // Returns unload the current entry.
         pcstk_pkg::OP_RETURN, pcstk_pkg::OP_RETURN_WITH_LITERAL,
         pcstk_pkg::OP_INTERRUPT_RETURN: begin
            pop = 1'b1;
            next_cur.pc = top;
         end

         // The offset is unsigned.
         pcstk_pkg::OP_JUMP_BY_WORK_OFFSET: begin
            next_cur.pc = branch_target(cur.pc, {7'h00, i_working});
         end

         // The operand is sign extended.
         pcstk_pkg::OP_RELATIVE_JUMP: begin
            next_cur.pc = branch_target(cur.pc, {{6{i_rel_operand[8]}}, i_rel_operand});
         end

         // Core write of the low byte.
         pcstk_pkg::OP_WRITE_PC_LOW: begin
            next_cur.pc = {cur.upper_address_latch, i_pc_low_wdata};
         end
         default: begin
         end
      endcase

      // Push: index is raised first, then the return address goes into the new slot.
      if (push) begin
         next_cur.stack_index = idx_up;
         stk.we = 1'b1;
         stk.waddr = slot_of(idx_up);
         stk.wdata = 15'(cur.pc + 15'h0001);
         // Index 0x0f holds the sixteenth entry.
         if (cur.stack_index == 5'h0f) begin
            next_cur.status[pcstk_pkg::OVF_BIT] = 1'b1;
            if (cur.stack_fault_reset_enable) begin
               next_cur.fault_reset = 1'b1;
               next_cur.pc = pcstk_pkg::PC_RESET;
               next_cur.stack_index = pcstk_pkg::STACK_INDEX_RESET;
               stk.we = 1'b0;
            end
         end
      end

      // Pop: the counter was loaded above, then the index drops.
      if (pop) begin
         next_cur.stack_index = 5'(cur.stack_index - 5'h01);
         // Popping an empty stack underflows.
         if (cur.stack_index == pcstk_pkg::STACK_INDEX_RESET) begin
            next_cur.status[pcstk_pkg::UNF_BIT] = 1'b1;
            if (cur.stack_fault_reset_enable) begin
               next_cur.fault_reset = 1'b1;
               next_cur.pc = pcstk_pkg::PC_RESET;
               next_cur.stack_index = pcstk_pkg::STACK_INDEX_RESET;
            end
         end
      end

      // APB access phase: answer after one wait state, writes land here.
      if (access && !cur.pready) begin
         next_cur.pready = 1'b1;
         next_cur.pslverr = !reg_hit;
         next_cur.prdata = 32'h0000_0000;
         if (i_pwrite) begin
            case (reg_index)
               // Shadow copies keep their implemented bits.
               pcstk_pkg::IDX_FLAGS_SHADOW: next_cur.flags_shadow = {5'h00, i_pwdata[2:0]};
               pcstk_pkg::IDX_WORKING_SHADOW: next_cur.working_shadow = i_pwdata[7:0];
               pcstk_pkg::IDX_BANK_SELECT_SHADOW:
                  next_cur.bank_select_shadow = {3'h0, i_pwdata[4:0]};
               pcstk_pkg::IDX_UPPER_LATCH_SHADOW:
                  next_cur.upper_latch_shadow = {1'b0, i_pwdata[6:0]};
               pcstk_pkg::IDX_POINTER0_LOW_SHADOW: next_cur.pointer0_low_shadow = i_pwdata[7:0];
               pcstk_pkg::IDX_POINTER0_HIGH_SHADOW: next_cur.pointer0_high_shadow = i_pwdata[7:0];
               pcstk_pkg::IDX_POINTER1_LOW_SHADOW: next_cur.pointer1_low_shadow = i_pwdata[7:0];
               pcstk_pkg::IDX_POINTER1_HIGH_SHADOW: next_cur.pointer1_high_shadow = i_pwdata[7:0];
               pcstk_pkg::IDX_STACK_INDEX: next_cur.stack_index = i_pwdata[4:0];

               // A top write patches one byte of the entry.
               pcstk_pkg::IDX_STACK_TOP_LOW: begin
                  if (!push) begin
                     stk.we = 1'b1;
                     stk.waddr = slot_of(cur.stack_index);
                     stk.wdata = {top[14:8], i_pwdata[7:0]};
                  end
               end
               pcstk_pkg::IDX_STACK_TOP_HIGH: begin
                  if (!push) begin
                     stk.we = 1'b1;
                     stk.waddr = slot_of(cur.stack_index);
                     stk.wdata = {i_pwdata[6:0], top[7:0]};
                  end
               end

               // Counter, latch, mask and control.
               pcstk_pkg::IDX_PC_LOW_BYTE: begin
                  next_cur.pc = {cur.upper_address_latch, i_pwdata[7:0]};
               end
               pcstk_pkg::IDX_UPPER_ADDRESS_LATCH: next_cur.upper_address_latch = i_pwdata[6:0];
               pcstk_pkg::IDX_IRQ_MASK: next_cur.mask = i_pwdata[1:0];
               pcstk_pkg::IDX_CONTROL: next_cur.stack_fault_reset_enable = i_pwdata[0];
               default: begin
               end
            endcase
         end else begin
            case (reg_index)
               // Shadow copies read in the low byte.
               pcstk_pkg::IDX_FLAGS_SHADOW: next_cur.prdata = {24'h00_0000, cur.flags_shadow};
               pcstk_pkg::IDX_WORKING_SHADOW: next_cur.prdata = {24'h00_0000, cur.working_shadow};
               pcstk_pkg::IDX_BANK_SELECT_SHADOW:
                  next_cur.prdata = {24'h00_0000, cur.bank_select_shadow};
               pcstk_pkg::IDX_UPPER_LATCH_SHADOW:
                  next_cur.prdata = {24'h00_0000, cur.upper_latch_shadow};
               pcstk_pkg::IDX_POINTER0_LOW_SHADOW:
                  next_cur.prdata = {24'h00_0000, cur.pointer0_low_shadow};
               pcstk_pkg::IDX_POINTER0_HIGH_SHADOW:
                  next_cur.prdata = {24'h00_0000, cur.pointer0_high_shadow};
               pcstk_pkg::IDX_POINTER1_LOW_SHADOW:
                  next_cur.prdata = {24'h00_0000, cur.pointer1_low_shadow};
               pcstk_pkg::IDX_POINTER1_HIGH_SHADOW:
                  next_cur.prdata = {24'h00_0000, cur.pointer1_high_shadow};

               // Stack index and top of stack.
               pcstk_pkg::IDX_STACK_INDEX: next_cur.prdata = {27'h000_0000, cur.stack_index};
               pcstk_pkg::IDX_STACK_TOP_LOW: begin
                  // Empty stack with fault reset on reads as zero.
                  if (!(cur.stack_fault_reset_enable && cur.stack_index[4])) begin
                     next_cur.prdata = {24'h00_0000, top[7:0]};
                  end
               end
               pcstk_pkg::IDX_STACK_TOP_HIGH: begin
                  if (!(cur.stack_fault_reset_enable && cur.stack_index[4])) begin
                     next_cur.prdata = {25'h000_0000, top[14:8]};
                  end
               end

               // Counter, latch, faults, mask and control.
               pcstk_pkg::IDX_PC_LOW_BYTE: next_cur.prdata = {24'h00_0000, cur.pc[7:0]};
               pcstk_pkg::IDX_UPPER_ADDRESS_LATCH:
                  next_cur.prdata = {25'h000_0000, cur.upper_address_latch};
               pcstk_pkg::IDX_FAULT_STATUS: begin
                  next_cur.prdata = {30'h0000_0000, cur.status};
                  // Read clears, but an event in this same cycle survives.
                  next_cur.status = next_cur.status & ~cur.status | (next_cur.status & ~cur.status);
                  next_cur.status[pcstk_pkg::OVF_BIT] =
                     (push && cur.stack_index == 5'h0f);
                  next_cur.status[pcstk_pkg::UNF_BIT] =
                     (pop && cur.stack_index == pcstk_pkg::STACK_INDEX_RESET);
               end
               pcstk_pkg::IDX_IRQ_MASK: next_cur.prdata = {30'h0000_0000, cur.mask};
               pcstk_pkg::IDX_CONTROL:
                  next_cur.prdata = {31'h0000_0000, cur.stack_fault_reset_enable};
               pcstk_pkg::IDX_PC_VIEW: next_cur.prdata = {17'h0_0000, cur.pc};
               default: begin
               end
            endcase
         end
      end

      // Level interrupt from the status that will stand next.
      next_cur.irq = |(next_cur.status & next_cur.mask);
   end

   // State register; hardware reset clears the counter and empties the stack.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         cur <= '0;
         cur.pc <= pcstk_pkg::PC_RESET;
         cur.stack_index <= pcstk_pkg::STACK_INDEX_RESET;
         cur.working_shadow <= pcstk_pkg::WORKING_SHADOW_RESET;
      end else if (i_ce) begin
         // Enable low holds every field.
         cur <= next_cur;
      end
   end

   assign o_pc = cur.pc;
   assign o_prdata = cur.prdata;
   assign o_pready = cur.pready;
   assign o_pslverr = cur.pslverr;
   assign o_fault_reset = cur.fault_reset;
   assign o_irq = cur.irq;
endmodule

// file: design/return_stack_mem.sv
// Sixteen-entry, 15-bit return-address store kept apart from program and data memory.
`timescale 1ns/1ps
module return_stack_mem #(
   parameter int DEPTH_BITS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_ce,
   stack_port_if.store port
);
   logic [14:0] mem [0:(1 << DEPTH_BITS)-1];

   // Entries have no reset; the write happens only while the clock enable is high.
   always_ff @(posedge i_clk_sys) begin
      if (i_ce && port.we) begin
         mem[port.waddr] <= port.wdata;
      end
   end

   // Combinational read of the indexed entry.
   assign port.rdata = mem[port.raddr];
endmodule

// file: include/pcstk_pkg.sv
// Package with register map, reset values and opcodes for the program counter and stack block.
package pcstk_pkg;
   // Register indices on APB; the byte address is four times the index.
   localparam logic [11:0] IDX_FLAGS_SHADOW = 12'h0fe4;
   localparam logic [11:0] IDX_WORKING_SHADOW = 12'h0fe5;
   localparam logic [11:0] IDX_BANK_SELECT_SHADOW = 12'h0fe6;
   localparam logic [11:0] IDX_UPPER_LATCH_SHADOW = 12'h0fe7;
   localparam logic [11:0] IDX_POINTER0_LOW_SHADOW = 12'h0fe8;
   localparam logic [11:0] IDX_POINTER0_HIGH_SHADOW = 12'h0fe9;
   localparam logic [11:0] IDX_POINTER1_LOW_SHADOW = 12'h0fea;
   localparam logic [11:0] IDX_POINTER1_HIGH_SHADOW = 12'h0feb;
   localparam logic [11:0] IDX_STACK_INDEX = 12'h0fed;
   localparam logic [11:0] IDX_STACK_TOP_LOW = 12'h0fee;
   localparam logic [11:0] IDX_STACK_TOP_HIGH = 12'h0fef;
   localparam logic [11:0] IDX_PC_LOW_BYTE = 12'h0f82;
   localparam logic [11:0] IDX_UPPER_ADDRESS_LATCH = 12'h0f8a;
   localparam logic [11:0] IDX_FAULT_STATUS = 12'h0ff0;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h0ff1;
   localparam logic [11:0] IDX_CONTROL = 12'h0ff2;
   localparam logic [11:0] IDX_PC_VIEW = 12'h0ff3;
   // Reset values.
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [4:0] STACK_INDEX_RESET = 5'h1f;
   localparam logic [7:0] WORKING_SHADOW_RESET = 8'h00;
   // Status bit positions.
   localparam int OVF_BIT = 0;
   localparam int UNF_BIT = 1;
   // Sequencer commands from the instruction decoder.
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_STEP = 4'h1,
      OP_CALL = 4'h2,
      OP_COMPUTED_CALL = 4'h3,
      OP_INTERRUPT = 4'h4,
      OP_RETURN = 4'h5,
      OP_RETURN_WITH_LITERAL = 4'h6,
      OP_INTERRUPT_RETURN = 4'h7,
      OP_JUMP_BY_WORK_OFFSET = 4'h8,
      OP_RELATIVE_JUMP = 4'h9,
      OP_WRITE_PC_LOW = 4'ha
   } pc_op_t;
endpackage

// file: include/stack_port_if.sv
// Interface between the sequencer and the return-address stack memory.
`timescale 1ns/1ps
interface stack_port_if #(parameter int DEPTH_BITS = 4);
   logic we;
   logic [DEPTH_BITS-1:0] waddr;
   logic [14:0] wdata;
   logic [DEPTH_BITS-1:0] raddr;
   logic [14:0] rdata;
   modport owner (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: sim/decoder_model.sv
// Behavioural model of the instruction decoder that issues sequencer commands.
`timescale 1ns/1ps
module decoder_model (
   input wire logic i_clk_sys,
   output logic [3:0] o_op,
   output logic [10:0] o_call_operand,
   output logic [8:0] o_rel_operand,
   output logic [7:0] o_working,
   output logic [7:0] o_pc_low_wdata,
   output logic [14:0] o_vector
);
   logic [14:0] last = 15'h0000;
   // Idle command and defined operands from time zero.
   initial begin
      o_op = 4'h0;
      {o_call_operand, o_rel_operand, o_working, o_pc_low_wdata, o_vector} = '0;
   end
   // Holds one command from an edge until the next edge takes it; interrupts are only
   // issued while software leaves the stack index alone.
   task automatic issue(input logic [3:0] op, input logic [14:0] arg);
      @(posedge i_clk_sys);
      o_op <= op;
      o_call_operand <= arg[10:0];
      o_rel_operand <= arg[8:0];
      o_working <= arg[7:0];
      o_pc_low_wdata <= arg[7:0];
      o_vector <= arg;
      last = arg;
   endtask
   // Lets the last command be taken, then drops it and scrambles the stale operands except the low-byte write data.
   task automatic idle();
      @(posedge i_clk_sys);
      o_op <= 4'h0;
      o_call_operand <= ~last[10:0];
      o_rel_operand <= ~last[8:0];
      o_working <= ~last[7:0];
      o_vector <= ~last;
      #1;
   endtask
endmodule

// file: sim/pcstk_checker.sv
// Port-level assertions for the program counter and stack block.
`timescale 1ns/1ps
module pcstk_checker (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [3:0] i_op,
   input wire logic [8:0] i_rel_operand,
   input wire logic [7:0] i_working,
   input wire logic [14:0] i_vector,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [14:0] o_pc,
   input wire logic o_fault_reset,
   input wire logic o_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // A call immediately followed by a return, and an APB access waiting for its answer.
   sequence s_push_pop;
      i_ce && (i_op == 4'h2 || i_op == 4'h3) ##1 i_ce && i_op == 4'h5;
   endsequence
   sequence s_taken;
      i_ce && i_psel && i_penable && !o_pready;
   endsequence
   // Reset is watched with no disable so that the cleared state itself is seen.
   property p_reset_clear;
      @(posedge i_clk_sys) disable iff (1'b0) !i_rst_n |=> o_pc == 15'h0000 && !o_irq;
   endproperty
   property p_return_restores;
      s_push_pop |=> o_fault_reset || o_pc == $past(o_pc, 2) + 15'h0001;
   endproperty
   property p_rel_jump;
      i_ce && i_op == 4'h9 |=> o_fault_reset
         || o_pc == $past(o_pc) + 15'h0001 + {{6{$past(i_rel_operand[8])}}, $past(i_rel_operand)};
   endproperty
   property p_work_jump;
      i_ce && i_op == 4'h8 |=> o_pc == $past(o_pc) + 15'h0001 + {7'h00, $past(i_working)};
   endproperty
   property p_vector;
      i_ce && i_op == 4'h4 |=> o_fault_reset || o_pc == $past(i_vector);
   endproperty
   property p_stall;
      !i_ce |=> $stable(o_pc);
   endproperty
   property p_answer;
      s_taken |=> o_pready;
   endproperty
   property p_ready_pulse;
      i_ce && o_pready |=> !o_pready;
   endproperty
   property p_err_with_ready;
      o_pslverr |-> o_pready;
   endproperty
   property p_fault_pulse;
      o_fault_reset |-> o_pc == 15'h0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("pc or irq not cleared");
   a_return_restores: assert property (p_return_restores) else $error("bad return");
   a_rel_jump: assert property (p_rel_jump) else $error("relative jump target bad");
   a_work_jump: assert property (p_work_jump) else $error("offset jump target bad");
   a_vector: assert property (p_vector) else $error("vector not loaded");
   a_stall: assert property (p_stall) else $error("pc moved while stalled");
   a_answer: assert property (p_answer) else $error("no ready after access");
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   a_fault_pulse: assert property (p_fault_pulse) else $error("fault without cleared pc");
endmodule
bind program_counter_and_stack pcstk_checker chk (.i_clk_sys, .i_rst_n, .i_ce, .i_op,
   .i_rel_operand, .i_working, .i_vector, .i_psel, .i_penable, .o_pready, .o_pslverr, .o_pc,
   .o_fault_reset, .o_irq);

// file: sim/tb_top.sv
// Self-checking testbench for the program counter and stack block.
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ce = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [13:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_fault_reset, o_irq;
   logic [14:0] o_pc, vec;
   logic [3:0] op;
   logic [10:0] call_arg;
   logic [8:0] rel_arg;
   logic [7:0] work, low_wd;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int n_compared = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   decoder_model core (.i_clk_sys, .o_op(op), .o_call_operand(call_arg), .o_rel_operand(rel_arg),
      .o_working(work), .o_pc_low_wdata(low_wd), .o_vector(vec));
   program_counter_and_stack uut (.i_clk_sys, .i_rst_n, .i_ce, .i_op(op),
      .i_call_operand(call_arg), .i_rel_operand(rel_arg), .i_working(work),
      .i_pc_low_wdata(low_wd), .i_vector(vec), .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pc, .o_fault_reset, .o_irq);
   // Counts every comparison and reports each mismatch.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One APB transfer: setup, then access held until ready is sampled high.
   task automatic reg_io(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
      int k;
      @(posedge i_clk_sys);
      {i_psel, i_penable, i_pwrite} <= {1'b1, 1'b0, wr};
      i_paddr <= {idx, 2'b00};
      i_pwdata <= {24'h00_0000, wd};
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clk_sys);
         if (o_pready === 1'b1) break;
      end
      rd = o_prdata;
      er = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
      if (k == 20) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic rdc(input string what, input logic [11:0] idx, input logic [31:0] exp);
      reg_io(1'b0, idx, 8'h00);
      check(what, rd, exp);
   endtask
   task automatic do_reset();
      @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      repeat (12) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
   endtask
   // Reset state, then every way of loading the counter except vectoring, and a push and pop round trip.
   task automatic t_loads();
      check("pc", o_pc, 15'h0000);
      rdc("index", pcstk_pkg::IDX_STACK_INDEX, 32'h0000_001f);
      reg_io(1'b1, pcstk_pkg::IDX_STACK_INDEX, 8'hff);
      rdc("index", pcstk_pkg::IDX_STACK_INDEX, 32'h0000_001f);
      reg_io(1'b1, pcstk_pkg::IDX_UPPER_ADDRESS_LATCH, 8'h2a);
      reg_io(1'b1, pcstk_pkg::IDX_PC_LOW_BYTE, 8'h34);
      check("pc", o_pc, 15'h2a34);
      core.issue(pcstk_pkg::OP_WRITE_PC_LOW, 15'h0056);
      core.idle();
      check("pc", o_pc, 15'h2a56);
      core.issue(pcstk_pkg::OP_CALL, 15'h0555);
      core.idle();
      check("pc", o_pc, {4'h5, 11'h555});
      rdc("index", pcstk_pkg::IDX_STACK_INDEX, 32'h0000_0000);
      rdc("top hi", pcstk_pkg::IDX_STACK_TOP_HIGH, 32'h0000_002a);
      rdc("top lo", pcstk_pkg::IDX_STACK_TOP_LOW, 32'h0000_0057);
      core.issue(pcstk_pkg::OP_COMPUTED_CALL, 15'h0077);
      core.issue(pcstk_pkg::OP_RETURN, 15'h0000);
      core.idle();
      check("pc", o_pc, {4'h5, 11'h555} + 15'h0001);
      core.issue(pcstk_pkg::OP_COMPUTED_CALL, 15'h0077);
      core.idle();
      check("pc", o_pc, 15'h2a77);
      core.issue(pcstk_pkg::OP_RETURN_WITH_LITERAL, 15'h0000);
      core.issue(pcstk_pkg::OP_INTERRUPT_RETURN, 15'h0000);
      core.idle();
      check("pc", o_pc, 15'h2a57);
      rdc("index", pcstk_pkg::IDX_STACK_INDEX, 32'h0000_001f);
      rdc("latch", pcstk_pkg::IDX_UPPER_ADDRESS_LATCH, 32'h0000_002a);
      reg_io(1'b1, pcstk_pkg::IDX_UPPER_ADDRESS_LATCH, 8'h01);
      reg_io(1'b1, pcstk_pkg::IDX_PC_LOW_BYTE, 8'hf0);
      core.issue(pcstk_pkg::OP_JUMP_BY_WORK_OFFSET, 15'h0020);
      core.idle();
      check("pc", o_pc, 15'h0211);
      core.issue(pcstk_pkg::OP_RELATIVE_JUMP, 15'h01f0);
      core.idle();
      check("pc", o_pc, 15'h0202);
      @(posedge i_clk_sys) i_ce <= 1'b0;
      core.issue(pcstk_pkg::OP_STEP, 15'h0000);
      core.idle();
      check("pc", o_pc, 15'h0202);
      @(posedge i_clk_sys) i_ce <= 1'b1;
      core.issue(pcstk_pkg::OP_STEP, 15'h0000);
      core.idle();
      check("pc", o_pc, 15'h0203);
   endtask
   // Seventeen interrupt pushes wrap onto the first entry and raise the overflow interrupt.
   task automatic t_wrap();
      do_reset();
      reg_io(1'b1, pcstk_pkg::IDX_IRQ_MASK, 8'h01);
      for (int k = 0; k < 17; k++) core.issue(pcstk_pkg::OP_INTERRUPT, 15'h0100 + 15'(k));
      core.idle();
      check("pc", o_pc, 15'h0110);
      check("irq", o_irq, 1'b1);
      rdc("status", pcstk_pkg::IDX_FAULT_STATUS, 32'h0000_0001);
      check("irq", o_irq, 1'b0);
      reg_io(1'b1, pcstk_pkg::IDX_STACK_INDEX, 8'h00);
      rdc("top hi", pcstk_pkg::IDX_STACK_TOP_HIGH, 32'h0000_0001);
      rdc("top lo", pcstk_pkg::IDX_STACK_TOP_LOW, 32'h0000_0010);
      reg_io(1'b1, pcstk_pkg::IDX_STACK_TOP_LOW, 8'h9c);
      reg_io(1'b1, pcstk_pkg::IDX_STACK_TOP_HIGH, 8'h35);
      rdc("top hi", pcstk_pkg::IDX_STACK_TOP_HIGH, 32'h0000_0035);
      rdc("top lo", pcstk_pkg::IDX_STACK_TOP_LOW, 32'h0000_009c);
   endtask
   // Underflow sets its flag; with the fault reset enabled it also resets the counter.
   task automatic t_underflow();
      do_reset();
      core.issue(pcstk_pkg::OP_RETURN, 15'h0000);
      core.idle();
      rdc("status", pcstk_pkg::IDX_FAULT_STATUS, 32'h0000_0002);
      reg_io(1'b1, pcstk_pkg::IDX_CONTROL, 8'h01);
      reg_io(1'b1, pcstk_pkg::IDX_PC_LOW_BYTE, 8'h44);
      reg_io(1'b1, pcstk_pkg::IDX_STACK_INDEX, 8'h1f);
      core.issue(pcstk_pkg::OP_RETURN, 15'h0000);
      core.idle();
      check("fault", o_fault_reset, 1'b1);
      check("pc", o_pc, 15'h0000);
      rdc("status", pcstk_pkg::IDX_FAULT_STATUS, 32'h0000_0002);
      rdc("top lo", pcstk_pkg::IDX_STACK_TOP_LOW, 32'h0000_0000);
      reg_io(1'b0, 12'h0fec, 8'h00);
      check("slverr", er, 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      #1;
      t_loads();
      t_wrap();
      t_underflow();
      tally_and_finish();
   end
endmodule
